// file: design/tsp_regs.svh
// register offsets, field positions, reset values and timing figures of the trace serial port
`ifndef TSP_REGS_SVH
`define TSP_REGS_SVH

`define TSP_DATA_OFS      8'h00
`define TSP_CTRL_OFS      8'h04

`define TSP_DATA_RST      8'h00
`define TSP_CTRL_RST      7'h00

`define TSP_CTRL_EN_BIT   0
`define TSP_CTRL_EDGE_BIT 1
`define TSP_CTRL_DIV_LSB  2
`define TSP_CTRL_DIV_MSB  3
`define TSP_CTRL_GAP_LSB  4
`define TSP_CTRL_GAP_MSB  6

`define TSP_SYS_CLK_HZ    100000000
`define TSP_RATE0_HZ      24000000
`define TSP_RATE1_HZ      12000000
`define TSP_RATE2_HZ      6000000

`define TSP_DIV_RESERVED  2'h3
`define TSP_BITS_PER_BYTE 8

`define TSP_RESP_OKAY     2'h0
`define TSP_RESP_SLVERR   2'h2

`endif

// file: design/tsp_pkg.sv
// types shared by the trace serial port
package tsp_pkg;

	typedef struct packed {
		logic [2:0] gap;
		logic [1:0] divSel;
		logic       edgeFall;
		logic       en;
	} tsp_ctrl_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_GAP
	} tsp_state_t;

endpackage : tsp_pkg

// file: design/tsp_clk_div.sv
// half-period tick generator for the serial output clock
`timescale 1ns/1ps
`include "tsp_regs.svh"

module tsp_clk_div #(
	parameter int SYS_CLK_HZ = `TSP_SYS_CLK_HZ
) (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic [1:0] divSel,
	output logic            tick
);
	localparam int H0 = (SYS_CLK_HZ / (2 * `TSP_RATE0_HZ)) < 1 ? 1 : SYS_CLK_HZ / (2 * `TSP_RATE0_HZ);
	localparam int H1 = (SYS_CLK_HZ / (2 * `TSP_RATE1_HZ)) < 1 ? 1 : SYS_CLK_HZ / (2 * `TSP_RATE1_HZ);
	localparam int H2 = (SYS_CLK_HZ / (2 * `TSP_RATE2_HZ)) < 1 ? 1 : SYS_CLK_HZ / (2 * `TSP_RATE2_HZ);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [7:0] limit;
	logic       tick_d;

	always_comb begin
		unique case (divSel)
			2'h0:    limit = 8'(H0 - 1);
			2'h1:    limit = 8'(H1 - 1);
			2'h2:    limit = 8'(H2 - 1);
			default: limit = 8'h00;
		endcase
		cnt_d  = cnt_q;
		tick_d = 1'b0;
		if (!run || divSel == `TSP_DIV_RESERVED) begin
			cnt_d = 8'h00;
		end else if (cnt_q >= limit) begin
			cnt_d  = 8'h00;
			tick_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_q <= 8'h00;
			tick  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick  <= tick_d;
		end
	end

	AST_RESERVED_NO_TICK: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(divSel == `TSP_DIV_RESERVED) |=> !tick)
		else $error("tick produced under reserved divider code");

endmodule : tsp_clk_div

// file: design/tsp_top.sv
// trace serial port: register slave on AXI4-Lite and byte serialiser
`timescale 1ns/1ps
`include "tsp_regs.svh"

module tsp_top #(
	parameter int SYS_CLK_HZ = `TSP_SYS_CLK_HZ,
	parameter int AW         = 8
) (
	input  wire logic          sys_clk,
	input  wire logic          sys_rst,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic               traceSerialClock,
	output logic               traceSerialOut
);
	localparam logic [AW-1:0] DATA_ADDR = AW'(`TSP_DATA_OFS);
	localparam logic [AW-1:0] CTRL_ADDR = AW'(`TSP_CTRL_OFS);

	// bus group
	logic               awHeld_q, awHeld_d, wHeld_q, wHeld_d;
	logic [AW-1:0]      awAddr_q, awAddr_d;
	logic [7:0]         wData_q, wData_d;
	logic               wStrb0_q, wStrb0_d;
	logic               awReady_d, wReady_d, bValid_d, arReady_d, rValid_d;
	logic [1:0]         bResp_d, rResp_d;
	logic [31:0]        rData_d;
	logic [7:0]         data_q, data_d;
	tsp_pkg::tsp_ctrl_t ctrl_q, ctrl_d;
	logic               wrIsData, wrIsCtrl, commit, loadStart, busy;
	logic [AW-1:0]      wordAddr;
	logic [AW-1:0]      rdWord;

	// engine group
	tsp_pkg::tsp_state_t state_q, state_d;
	logic [7:0]          shift_q, shift_d;
	logic [4:0]          halfCnt_q, halfCnt_d;
	logic [3:0]          gapCnt_q, gapCnt_d;
	logic [2:0]          gapLat_q, gapLat_d;
	logic                edgeLat_q, edgeLat_d;
	logic                clk_d, dat_d;
	logic [4:0]          lastHalf;
	logic                tick;

	assign busy      = state_q != tsp_pkg::ST_IDLE;
	assign wordAddr  = {awAddr_q[AW-1:2], 2'b00};
	assign wrIsData  = wordAddr == DATA_ADDR;
	assign wrIsCtrl  = wordAddr == CTRL_ADDR;
	assign commit    = awHeld_q && wHeld_q && !s_axi_bvalid && !(wrIsData && busy);
	assign loadStart = commit && wrIsData && wStrb0_q && ctrl_q.en
		&& ctrl_q.divSel != `TSP_DIV_RESERVED;
	assign rdWord    = {s_axi_araddr[AW-1:2], 2'b00};

	always_comb begin
		awHeld_d  = awHeld_q;
		wHeld_d   = wHeld_q;
		awAddr_d  = awAddr_q;
		wData_d   = wData_q;
		wStrb0_d  = wStrb0_q;
		bValid_d  = s_axi_bvalid;
		bResp_d   = s_axi_bresp;
		arReady_d = s_axi_arready;
		rValid_d  = s_axi_rvalid;
		rData_d   = s_axi_rdata;
		rResp_d   = s_axi_rresp;
		data_d    = data_q;
		ctrl_d    = ctrl_q;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_d  = 1'b1;
			wData_d  = s_axi_wdata[7:0];
			wStrb0_d = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bValid_d = 1'b0;
		end
		if (commit) begin
			awHeld_d = 1'b0;
			wHeld_d  = 1'b0;
			bValid_d = 1'b1;
			bResp_d  = (wrIsData || wrIsCtrl) ? `TSP_RESP_OKAY : `TSP_RESP_SLVERR;
			if (wrIsData && wStrb0_q) begin
				data_d = wData_q;
			end
			if (wrIsCtrl && wStrb0_q) begin
				ctrl_d = tsp_pkg::tsp_ctrl_t'(wData_q[`TSP_CTRL_GAP_MSB:`TSP_CTRL_EN_BIT]);
			end
		end
		awReady_d = !awHeld_d;
		wReady_d  = !wHeld_d;
		if (s_axi_rvalid && s_axi_rready) begin
			rValid_d  = 1'b0;
			arReady_d = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			arReady_d = 1'b0;
			rValid_d  = 1'b1;
			rResp_d   = `TSP_RESP_OKAY;
			if (rdWord == DATA_ADDR) begin
				rData_d = {24'h000000, data_q};
			end else if (rdWord == CTRL_ADDR) begin
				rData_d = {25'h0, ctrl_q};
			end else begin
				rData_d = 32'h00000000;
				rResp_d = `TSP_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			awHeld_q      <= 1'b0;
			wHeld_q       <= 1'b0;
			awAddr_q      <= '0;
			wData_q       <= 8'h00;
			wStrb0_q      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `TSP_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `TSP_RESP_OKAY;
			data_q        <= `TSP_DATA_RST;
			ctrl_q        <= `TSP_CTRL_RST;
		end else begin
			awHeld_q      <= awHeld_d;
			wHeld_q       <= wHeld_d;
			awAddr_q      <= awAddr_d;
			wData_q       <= wData_d;
			wStrb0_q      <= wStrb0_d;
			s_axi_awready <= awReady_d;
			s_axi_wready  <= wReady_d;
			s_axi_bvalid  <= bValid_d;
			s_axi_bresp   <= bResp_d;
			s_axi_arready <= arReady_d;
			s_axi_rvalid  <= rValid_d;
			s_axi_rdata   <= rData_d;
			s_axi_rresp   <= rResp_d;
			data_q        <= data_d;
			ctrl_q        <= ctrl_d;
		end
	end

	tsp_clk_div #(
		.SYS_CLK_HZ(SYS_CLK_HZ)
	) uDiv (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.run    (busy),
		.divSel (ctrl_q.divSel),
		.tick   (tick)
	);

	// rising-edge shifting needs one extra low half so the last bit sees a falling edge
	assign lastHalf = edgeLat_q ? 5'd15 : 5'd16;

	always_comb begin
		state_d   = state_q;
		shift_d   = shift_q;
		halfCnt_d = halfCnt_q;
		gapCnt_d  = gapCnt_q;
		gapLat_d  = gapLat_q;
		edgeLat_d = edgeLat_q;
		clk_d     = traceSerialClock;
		dat_d     = traceSerialOut;
		unique case (state_q)
			tsp_pkg::ST_IDLE: begin
				clk_d = 1'b1;
				dat_d = 1'b1;
				if (loadStart) begin
					state_d   = tsp_pkg::ST_SHIFT;
					shift_d   = wData_q;
					halfCnt_d = 5'd0;
					gapLat_d  = ctrl_q.gap;
					edgeLat_d = ctrl_q.edgeFall;
				end
			end
			tsp_pkg::ST_SHIFT: begin
				if (tick) begin
					if (!halfCnt_q[0]) begin
						clk_d = 1'b0;
						if (edgeLat_q) begin
							dat_d = shift_q[halfCnt_q[3:1]];
						end
					end else begin
						clk_d = 1'b1;
						if (!edgeLat_q) begin
							dat_d = shift_q[halfCnt_q[3:1]];
						end
					end
					if (halfCnt_q == lastHalf) begin
						state_d  = tsp_pkg::ST_GAP;
						gapCnt_d = 4'd0;
					end else begin
						halfCnt_d = halfCnt_q + 5'd1;
					end
				end
			end
			tsp_pkg::ST_GAP: begin
				if (tick) begin
					clk_d = 1'b1;
					dat_d = 1'b1;
					if (gapCnt_q == {gapLat_q, 1'b1}) begin
						state_d = tsp_pkg::ST_IDLE;
					end else begin
						gapCnt_d = gapCnt_q + 4'd1;
					end
				end
			end
			default: begin
				state_d = tsp_pkg::ST_IDLE;
			end
		endcase
		if (!ctrl_q.en) begin
			state_d = tsp_pkg::ST_IDLE;
			clk_d   = 1'b1;
			dat_d   = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q          <= tsp_pkg::ST_IDLE;
			shift_q          <= 8'h00;
			halfCnt_q        <= 5'd0;
			gapCnt_q         <= 4'd0;
			gapLat_q         <= 3'd0;
			edgeLat_q        <= 1'b0;
			traceSerialClock <= 1'b1;
			traceSerialOut   <= 1'b1;
		end else begin
			state_q          <= state_d;
			shift_q          <= shift_d;
			halfCnt_q        <= halfCnt_d;
			gapCnt_q         <= gapCnt_d;
			gapLat_q         <= gapLat_d;
			edgeLat_q        <= edgeLat_d;
			traceSerialClock <= clk_d;
			traceSerialOut   <= dat_d;
		end
	end

	AST_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state_q == tsp_pkg::ST_IDLE) |-> (traceSerialClock && traceSerialOut))
		else $error("outputs not high while idle");
	AST_WRITE_STALL: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(busy && awHeld_q && wHeld_q && wrIsData && !s_axi_bvalid) |=> !s_axi_bvalid)
		else $error("data write answered during a transfer");
	AST_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
		loadStart |=> (state_q == tsp_pkg::ST_SHIFT && shift_q == $past(wData_q) && halfCnt_q == 5'd0))
		else $error("data write did not load the shifter");
	AST_DISABLED_CLK: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!ctrl_q.en |=> (traceSerialClock && state_q == tsp_pkg::ST_IDLE))
		else $error("clock runs while disabled");
	AST_FALL_SHIFT: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state_q == tsp_pkg::ST_SHIFT && edgeLat_q && $changed(traceSerialOut)) |-> $fell(traceSerialClock))
		else $error("data moved off the falling edge");
	AST_RISE_SHIFT: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state_q == tsp_pkg::ST_SHIFT && !edgeLat_q && $changed(traceSerialOut)) |-> $rose(traceSerialClock))
		else $error("data moved off the rising edge");
	AST_GAP_LEN: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state_q == tsp_pkg::ST_GAP ##1 state_q == tsp_pkg::ST_IDLE && ctrl_q.en && $past(ctrl_q.en))
		|-> $past(gapCnt_q) == {gapLat_q, 1'b1})
		else $error("inter-byte gap has wrong length");
	AST_BYTE_DONE: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state_q == tsp_pkg::ST_SHIFT && tick && halfCnt_q == lastHalf && ctrl_q.en)
		|=> state_q == tsp_pkg::ST_GAP)
		else $error("shifter did not finish after the last half period");

endmodule : tsp_top

// file: dv/tsp_trace_rx.sv
// trace capture receiver model on the far side of the serial link
`timescale 1ns/1ps

module tsp_trace_rx (
	input  wire logic  traceSerialClock,
	input  wire logic  traceSerialOut,
	input  wire logic  edgeFall,
	input  wire logic  clr,
	output logic [7:0] rxByte,
	output int         rxCount
);
	logic [7:0] shiftReg = 8'h00;
	int         bitCnt   = 0;
	logic       pend     = 1'b0;
	logic       skip     = 1'b0;

	initial rxByte = 8'h00;
	initial rxCount = 0;

	task automatic take();
		shiftReg = {traceSerialOut, shiftReg[7:1]};
		bitCnt++;
		if (bitCnt == 8) begin
			rxByte = shiftReg;
			rxCount++;
			bitCnt = 0;
			// in rising-edge mode the next rise opens the gap and carries no bit
			skip = (edgeFall === 1'b0);
		end
	endtask : take

	// falling-edge shifting: sample on rising clock
	always @(posedge traceSerialClock) begin
		if (!clr && edgeFall === 1'b1) take();
		else if (!clr) begin
			pend = !skip;
			skip = 1'b0;
		end
	end

	// rising-edge shifting: sample on falling clock once a bit was presented
	always @(negedge traceSerialClock) begin
		if (!clr && edgeFall === 1'b0 && pend) begin
			take();
			pend = 1'b0;
		end
	end

	// drop a partial byte after an aborted frame
	always @(posedge clr) begin
		bitCnt = 0;
		pend = 1'b0;
		skip = 1'b0;
	end
endmodule : tsp_trace_rx

// file: dv/tb.sv
// self-checking bench for the trace serial port
`timescale 1ns/1ps
`include "tsp_regs.svh"

module tb;
	logic        sys_clk = 1'b0, sys_rst = 1'b1, edgeSel = 1'b0, rxClr = 1'b0, clkD = 1'b1, outD = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rxByte, d, ctl;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        traceSerialClock, traceSerialOut;
	int          error_cnt = 0, check_count = 0, cyc = 0, lastChg = 0, rxCount, h, t0;
	int          spans[$];

	tsp_top u_dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .traceSerialClock, .traceSerialOut);

	tsp_trace_rx u_rx (.traceSerialClock, .traceSerialOut, .edgeFall(edgeSel), .clr(rxClr), .rxByte, .rxCount);

	always #5 sys_clk = ~sys_clk;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// clock span recorder and shifting-edge watch
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		clkD <= traceSerialClock;
		outD <= traceSerialOut;
		if (!sys_rst && traceSerialClock !== clkD) begin
			spans.push_back(cyc - lastChg);
			lastChg <= cyc;
			if (traceSerialOut !== outD) chk("shift_edge", {31'h0, ~edgeSel}, {31'h0, traceSerialClock});
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] dv, input logic [3:0] s, output logic [1:0] r);
		int t = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h0, dv};
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			t++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && t < 4000);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
		chk("wr_answer", 1, t < 4000);
	endtask : wr

	task automatic rdr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		int t = 0;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			t++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && t < 4000);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		r = s_axi_rresp;
		chk("rd_answer", 1, t < 4000);
	endtask : rdr

	task automatic waitRx(input int n);
		for (int t = 0; t < 3000 && rxCount < n; t++) @(posedge sys_clk);
		chk("rx_count", n, rxCount);
	endtask : waitRx

	task automatic conclude();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude

	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		conclude();
	end

	initial begin
		rxClr <= 1'b1;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rxClr <= 1'b0;
		@(posedge sys_clk);
		chk("idle_lines", 2'b11, {traceSerialClock, traceSerialOut});
		rdr(`TSP_CTRL_OFS, rd, resp);
		chk("ctrl_reset", `TSP_CTRL_RST, rd);
		rdr(`TSP_DATA_OFS, rd, resp);
		chk("data_reset", `TSP_DATA_RST, rd);
		rdr(8'h10, rd, resp);
		chk("rd_unmapped", `TSP_RESP_SLVERR, resp);
		wr(8'h08, 8'hFF, 4'hF, resp);
		chk("wr_unmapped", `TSP_RESP_SLVERR, resp);
		$display("test reset done");
		for (int c = 0; c < 6; c++) begin
			h = 2 << (c / 2);
			ctl = {4'h0, 2'(c / 2), c[0], 1'b1};
			d = 8'h96 + 8'(c * 37);
			edgeSel <= c[0];
			wr(`TSP_CTRL_OFS, ctl, 4'h1, resp);
			rdr(`TSP_CTRL_OFS, rd, resp);
			chk("ctrl_rb", ctl, rd);
			spans.delete();
			wr(`TSP_DATA_OFS, d, 4'h1, resp);
			waitRx(c + 1);
			repeat (4 * h + 5) @(posedge sys_clk);
			chk("rx_byte", d, rxByte);
			chk("clk_changes", c[0] ? 16 : 18, spans.size());
			chk("half_period", h, spans[2]);
			chk("after_lines", 2'b11, {traceSerialClock, traceSerialOut});
		end
		$display("test rates done");
		edgeSel <= 1'b0;
		wr(`TSP_CTRL_OFS, 8'h71, 4'h1, resp);
		spans.delete();
		wr(`TSP_DATA_OFS, 8'hA5, 4'h1, resp);
		t0 = cyc;
		fork
			wr(`TSP_DATA_OFS, 8'h3C, 4'h1, resp);
			begin
				repeat (10) @(posedge sys_clk);
				chk("stall_ready", 3'h1, {s_axi_awready, s_axi_wready, s_axi_arready});
			end
		join
		chk("stall", 1, cyc - t0 >= 66);
		chk("rx_first", 8'hA5, rxByte);
		waitRx(8);
		chk("rx_second", 8'h3C, rxByte);
		chk("gap", 1, spans[18] >= 32);
		$display("test gap done");
		wr(`TSP_CTRL_OFS, 8'h01, 4'h1, resp);
		wr(`TSP_DATA_OFS, 8'hFF, 4'h1, resp);
		repeat (9) @(posedge sys_clk);
		wr(`TSP_CTRL_OFS, 8'h00, 4'h1, resp);
		repeat (2) @(posedge sys_clk);
		chk("abort_lines", 2'b11, {traceSerialClock, traceSerialOut});
		rxClr <= 1'b1;
		@(posedge sys_clk);
		rxClr <= 1'b0;
		for (int c = 0; c < 2; c++) begin
			wr(`TSP_CTRL_OFS, c ? 8'hFF : 8'h00, 4'h1, resp);
			rdr(`TSP_CTRL_OFS, rd, resp);
			chk("ctrl_rsvd", c ? 8'h7F : 8'h00, rd);
			spans.delete();
			wr(`TSP_DATA_OFS, 8'h5A, 4'h1, resp);
			repeat (60) @(posedge sys_clk);
			chk("no_clock", 0, spans.size());
		end
		wr(`TSP_DATA_OFS, 8'h77, 4'h0, resp);
		rdr(`TSP_DATA_OFS, rd, resp);
		chk("data_rb", 8'h5A, rd);
		$display("test disable done");
		conclude();
	end
endmodule : tb
